// File: pkg/sdc_pkg.sv
package sdc_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ROW_W   = 12;
  localparam int COL_W   = 8;
  localparam int BANK_W  = 2;
  localparam int DQ_W    = 16;
  localparam int ADDR_W  = 12;
  localparam int UADDR_W = BANK_W + ROW_W + COL_W;
  // ----------------------------------------------------------------
  // commands as {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_MRS  = 3'h0;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam int         AP_BIT   = 10;
  // ----------------------------------------------------------------
  // mode word fields and codes
  // ----------------------------------------------------------------
  localparam int         MR_BL_LSB = 0;
  localparam int         MR_BT_BIT = 3;
  localparam int         MR_CL_LSB = 4;
  localparam logic [2:0] BL_1      = 3'h0;
  localparam logic [2:0] BL_2      = 3'h1;
  localparam logic [2:0] BL_4      = 3'h2;
  localparam logic [2:0] BL_8      = 3'h3;
  localparam logic [2:0] BL_PAGE   = 3'h7;
  localparam logic [2:0] CL_RST    = 3'h2;
  localparam logic [2:0] CL_MAX    = 3'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_RP_NS       = 20;
  localparam int T_RCD_NS      = 20;
  localparam int T_RC_NS       = 63;
  localparam int T_MRD_NS      = 80;
  localparam int T_REFI_NS     = 15625;
  localparam int T_INIT_NS     = 200000;
  localparam int INIT_REFS     = 2;
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RP_CYC   = cyc_min(T_RP_NS);
  localparam int RCD_CYC  = cyc_min(T_RCD_NS);
  localparam int RC_CYC   = cyc_min(T_RC_NS);
  localparam int MRD_CYC  = cyc_min(T_MRD_NS);
  localparam int REFI_CYC = cyc_max(T_REFI_NS);
  localparam int INIT_CYC = cyc_min(T_INIT_NS);
endpackage

// File: pkg/sdc_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdc_mem_if;
  import sdc_pkg::*;
  logic              clk_en;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic              bank_select_lo;
  logic              bank_select_hi;
  logic [ADDR_W-1:0] addr;
  logic              lower_byte_mask;
  logic              upper_byte_mask;
  logic [DQ_W-1:0]   dq_ctl;
  logic              dq_ctl_oe;
  logic [DQ_W-1:0]   dq_dev;
  logic              dq_dev_oe;
  logic [DQ_W-1:0]   data_lines;
  // resolved bus level; an undriven bus reads as zero
  assign data_lines = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);
  modport device (
    input  clk_en, cs_n, ras_n, cas_n, we_n, bank_select_lo,
    input  bank_select_hi, addr, lower_byte_mask, upper_byte_mask,
    input  data_lines,
    output dq_dev, dq_dev_oe
  );
  modport host (
    output clk_en, cs_n, ras_n, cas_n, we_n, bank_select_lo,
    output bank_select_hi, addr, lower_byte_mask, upper_byte_mask,
    output dq_ctl, dq_ctl_oe,
    input  data_lines
  );
endinterface
`default_nettype wire

// File: core/sdc_device.sv
// Overview of operation
// [RULE1] all pins sampled on rising clock only
// [RULE2] live edges advance burst and output registers
// [RULE3] clock enable low freezes outputs and burst
// [RULE4] low power entered only with all banks idle
// [RULE5] clock enable watched asynchronously in low power; here it is sampled on the rising clock
// [RULE6] controller opens a row before access
// [RULE7] burst length 1, 2, 4, 8 or page
// [RULE8] sequential or interleaved burst order
// [RULE9] read data after latency two or three
// [RULE10] burst stop ends a burst early
// [RULE11] auto precharge closes row after burst
// [RULE12] four banks of one million 16-bit words
// [RULE13] bank select 00 picks first bank
// [RULE14] codes 01, 10, 11 pick banks two-four
// [RULE15] row, column and precharge address use
// [RULE16] chip select high masks every command
// [RULE17] strobe decode of open, precharge, read, write
// [RULE18] controller refreshes 4096 times per 64 ms
`timescale 1ns/1ps
`default_nettype none
module sdc_device #(
  parameter int ROWS_W = sdc_pkg::ROW_W,
  parameter int COLS_W = sdc_pkg::COL_W
) (
  // clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  // memory pins
  sdc_mem_if.device                          mem_if,
  // status
  output var  logic                          powered_down_out,
  output var  logic                          self_refresh_out,
  output var  logic [3:0]                    bank_open_out
);
  import sdc_pkg::*;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam int IDX_W = BANK_W + ROWS_W + COLS_W;
  logic [DQ_W-1:0] mem [0:(2**IDX_W)-1]; // RULE12
  typedef enum logic [1:0] {SDC_RUN, SDC_PDN, SDC_SREF} sdc_pwr_t;
  sdc_pwr_t          pwr;
  logic              clk_live;
  logic [3:0]        bank_open;
  logic [ROWS_W-1:0] open_row [0:3];
  logic [2:0]        mode_bl;
  logic              mode_bt;
  logic [2:0]        mode_cl;
  logic              bst_act;
  logic              bst_wr;
  logic              bst_ap;
  logic [1:0]        bst_bank;
  logic [COLS_W-1:0] bst_col;
  logic [COLS_W-1:0] bst_cnt;
  logic              p0_v;
  logic              p1_v;
  logic [DQ_W-1:0]   p0_d;
  logic [DQ_W-1:0]   p1_d;
  logic [DQ_W-1:0]   dq_q;
  logic              dq_oe_q;
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [2:0]        cmd;
  logic [1:0]        bank;
  logic              live;
  logic              all_idle;
  assign cmd  = {mem_if.ras_n, mem_if.cas_n, mem_if.we_n}; // RULE17
  assign bank = {mem_if.bank_select_hi, mem_if.bank_select_lo}; // RULE13
  // commands count only on an unfrozen edge in normal power
  assign live = clk_live && (pwr == SDC_RUN) && !mem_if.cs_n; // RULE16
  assign all_idle = (bank_open == 4'h0) && !bst_act;
  logic new_acc;
  assign new_acc = live && (cmd == CMD_RD || cmd == CMD_WR)
                   && bank_open[bank]; // RULE6
  // ----------------------------------------------------------------
  // burst address generation
  // ----------------------------------------------------------------
  logic [COLS_W-1:0] len_last;
  always_comb begin
    case (mode_bl) // RULE7
      BL_1:    len_last = '0;
      BL_2:    len_last = COLS_W'(1);
      BL_4:    len_last = COLS_W'(3);
      BL_8:    len_last = COLS_W'(7);
      BL_PAGE: len_last = '1;
      default: len_last = '0;
    endcase
  end

  logic              acc_go;
  logic              acc_wr;
  logic              acc_ap;
  logic [1:0]        acc_bank;
  logic [COLS_W-1:0] acc_base;
  logic [COLS_W-1:0] acc_cnt;
  logic [COLS_W-1:0] acc_off;
  logic [COLS_W-1:0] acc_col;
  logic              acc_last;
  logic [IDX_W-1:0]  acc_idx;
  always_comb begin
    if (new_acc) begin
      acc_go   = 1'b1;
      acc_wr   = (cmd == CMD_WR);
      acc_ap   = mem_if.addr[AP_BIT]; // RULE15
      acc_bank = bank; // RULE14
      acc_base = mem_if.addr[COLS_W-1:0]; // RULE15
      acc_cnt  = '0;
    end else begin
      acc_go   = clk_live && bst_act;
      acc_wr   = bst_wr;
      acc_ap   = bst_ap;
      acc_bank = bst_bank;
      acc_base = bst_col;
      acc_cnt  = bst_cnt;
    end
    // page bursts always run linearly and wrap within the row
    if (mode_bt && mode_bl != BL_PAGE)
      acc_off = acc_base ^ acc_cnt; // RULE8
    else
      acc_off = acc_base + acc_cnt; // RULE8
    acc_col  = (acc_base & ~len_last) | (acc_off & len_last);
    acc_last = (acc_cnt == len_last) && (mode_bl != BL_PAGE);
    acc_idx  = {acc_bank, open_row[acc_bank], acc_col};
  end
  // ----------------------------------------------------------------
  // power state and clock suspend
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin // RULE1
    if (reset_in) begin
      pwr      <= SDC_RUN;
      clk_live <= 1'b1;
    end else if (pwr != SDC_RUN) begin
      // inputs other than clock enable are ignored here
      if (mem_if.clk_en) begin // RULE5
        pwr      <= SDC_RUN;
        clk_live <= 1'b1;
      end
    end else begin
      clk_live <= mem_if.clk_en; // RULE3
      if (clk_live && !mem_if.clk_en && all_idle) begin // RULE4
        if (!mem_if.cs_n && cmd == CMD_REF)
          pwr <= SDC_SREF;
        else
          pwr <= SDC_PDN;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode word
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_bl <= BL_1;
      mode_bt <= 1'b0;
      mode_cl <= CL_RST;
    end else if (live && cmd == CMD_MRS && all_idle) begin
      mode_bl <= mem_if.addr[MR_BL_LSB+:3];
      mode_bt <= mem_if.addr[MR_BT_BIT];
      // only latencies 2 and 3 exist; other codes fall back to 2
      mode_cl <= (mem_if.addr[MR_CL_LSB+:3] == CL_MAX) ? CL_MAX : CL_RST;
    end
  end
  // ----------------------------------------------------------------
  // banks and bursts
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bank_open <= 4'h0;
      bst_act   <= 1'b0;
      bst_wr    <= 1'b0;
      bst_ap    <= 1'b0;
      bst_bank  <= 2'h0;
      bst_col   <= '0;
      bst_cnt   <= '0;
      for (int b = 0; b < 4; b++)
        open_row[b] <= '0;
    end else if (clk_live) begin // RULE2 RULE3
      if (live && cmd == CMD_ACT && !bank_open[bank]) begin // RULE17
        bank_open[bank] <= 1'b1;
        open_row[bank]  <= mem_if.addr[ROWS_W-1:0]; // RULE15
      end
      if (live && cmd == CMD_PRE) begin
        if (mem_if.addr[AP_BIT]) // RULE15
          bank_open <= 4'h0;
        else
          bank_open[bank] <= 1'b0;
        if (mem_if.addr[AP_BIT] || bank == bst_bank)
          bst_act <= 1'b0;
      end
      if (live && cmd == CMD_STOP) begin
        bst_act <= 1'b0; // RULE10
      end else if (acc_go) begin
        if (new_acc) begin
          bst_wr   <= acc_wr;
          bst_ap   <= acc_ap;
          bst_bank <= acc_bank;
          bst_col  <= acc_base;
        end
        if (acc_last) begin
          bst_act <= 1'b0;
          if (acc_ap)
            bank_open[acc_bank] <= 1'b0; // RULE11
        end else begin
          bst_act <= 1'b1;
          bst_cnt <= acc_cnt + COLS_W'(1); // RULE2
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // write port: masked lanes keep their old byte
  // ----------------------------------------------------------------
  logic [1:0] lane_mask;
  assign lane_mask = {mem_if.upper_byte_mask, mem_if.lower_byte_mask};
  always_ff @(posedge ref_clk_in) begin
    if (!reset_in && acc_go && acc_wr && !(live && cmd == CMD_STOP)) begin
      for (int l = 0; l < 2; l++)
        if (!lane_mask[l])
          mem[acc_idx][8*l+:8] <= mem_if.data_lines[8*l+:8];
    end
  end
  // ----------------------------------------------------------------
  // read pipeline: stage 0 feeds latency 2, stage 1 latency 3
  // ----------------------------------------------------------------
  logic rd_take;
  assign rd_take = acc_go && !acc_wr && !(live && cmd == CMD_STOP)
                   && !(&lane_mask);
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      p0_v    <= 1'b0;
      p1_v    <= 1'b0;
      p0_d    <= '0;
      p1_d    <= '0;
      dq_q    <= '0;
      dq_oe_q <= 1'b0;
    end else if (clk_live) begin // RULE2 RULE3
      p0_v <= rd_take;
      p0_d <= rd_take ? mem[acc_idx] : '0;
      p1_v <= p0_v;
      p1_d <= p0_d;
      if (mode_cl == CL_MAX) begin // RULE9
        dq_q    <= p1_d;
        dq_oe_q <= p1_v;
      end else begin
        dq_q    <= p0_d;
        dq_oe_q <= p0_v;
      end
    end
  end
  assign mem_if.dq_dev    = dq_q;
  assign mem_if.dq_dev_oe = dq_oe_q;

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      powered_down_out <= 1'b0;
      self_refresh_out <= 1'b0;
      bank_open_out    <= 4'h0;
    end else begin
      powered_down_out <= (pwr == SDC_PDN);
      self_refresh_out <= (pwr == SDC_SREF);
      bank_open_out    <= bank_open;
    end
  end
endmodule
`default_nettype wire

// File: core/sdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_host #(
  parameter int          INIT_WAIT = sdc_pkg::INIT_CYC,
  parameter int          REFI      = sdc_pkg::REFI_CYC,
  parameter logic [2:0]  CAS_LAT   = sdc_pkg::CL_RST
) (
  // clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  // memory pins
  sdc_mem_if.host                            mem_if,
  // user requests
  input  wire logic                          req_valid_in,
  input  wire logic                          req_write_in,
  input  wire logic [sdc_pkg::UADDR_W-1:0]   req_addr_in,
  input  wire logic [sdc_pkg::DQ_W-1:0]      req_wdata_in,
  input  wire logic [1:0]                    req_mask_in,
  input  wire logic                          pdn_req_in,
  // user answers
  output var  logic                          req_ready_out,
  output var  logic [sdc_pkg::DQ_W-1:0]      rd_data_out,
  output var  logic                          rd_valid_out,
  output var  logic                          init_done_out,
  output var  logic                          powered_down_out
);
  import sdc_pkg::*;
  typedef enum logic [3:0] {
    SH_INIT, SH_PRE, SH_REF, SH_MRS, SH_IDLE, SH_RW, SH_WAIT, SH_PDN
  } sdc_hst_t;
  sdc_hst_t             st;
  sdc_hst_t             ret_st;
  logic [15:0]          wait_cnt;
  logic [15:0]          ref_tmr;
  logic                 ref_due;
  logic [1:0]           ref_left;
  logic [3:0]           rd_cnt;
  logic                 acc_wr;
  logic [UADDR_W-1:0]   acc_addr;
  logic [DQ_W-1:0]      acc_data;
  logic [1:0]           acc_mask;
  logic                 ref_issue;

  // ----------------------------------------------------------------
  // refresh pacing: set wins over the clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ref_tmr <= '0;
      ref_due <= 1'b0;
    end else if (ref_tmr == 16'(REFI - 1)) begin
      ref_tmr <= '0;
      ref_due <= 1'b1; // RULE18
    end else begin
      ref_tmr <= ref_tmr + 16'h0001;
      if (ref_issue)
        ref_due <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign ref_issue = (st == SH_REF);
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st               <= SH_INIT;
      ret_st           <= SH_IDLE;
      wait_cnt         <= '0;
      ref_left         <= 2'h0;
      acc_wr           <= 1'b0;
      acc_addr         <= '0;
      acc_data         <= '0;
      acc_mask         <= 2'h0;
      init_done_out    <= 1'b0;
      req_ready_out    <= 1'b0;
      powered_down_out <= 1'b0;
      mem_if.clk_en    <= 1'b1;
      mem_if.cs_n      <= 1'b1;
      {mem_if.ras_n, mem_if.cas_n, mem_if.we_n} <= CMD_NOP;
      {mem_if.bank_select_hi, mem_if.bank_select_lo} <= 2'h0;
      mem_if.addr      <= '0;
      mem_if.dq_ctl    <= '0;
      mem_if.dq_ctl_oe <= 1'b0;
      mem_if.lower_byte_mask <= 1'b0;
      mem_if.upper_byte_mask <= 1'b0;
    end else begin
      mem_if.cs_n      <= 1'b1;
      {mem_if.ras_n, mem_if.cas_n, mem_if.we_n} <= CMD_NOP;
      mem_if.dq_ctl_oe <= 1'b0;
      req_ready_out    <= 1'b0;
      case (st)
        SH_INIT: begin
          if (wait_cnt == 16'(INIT_WAIT - 1)) begin
            wait_cnt <= '0;
            st       <= SH_PRE;
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        SH_PRE: begin
          mem_if.cs_n <= 1'b0;
          {mem_if.ras_n, mem_if.cas_n, mem_if.we_n} <= CMD_PRE;
          mem_if.addr[AP_BIT] <= 1'b1; // RULE15
          ref_left <= 2'(INIT_REFS);
          wait_cnt <= 16'(RP_CYC);
          ret_st   <= SH_REF;
          st       <= SH_WAIT;
        end
        SH_REF: begin
          mem_if.cs_n <= 1'b0;
          {mem_if.ras_n, mem_if.cas_n, mem_if.we_n} <= CMD_REF; // RULE18
          ref_left <= ref_left - 2'h1;
          wait_cnt <= 16'(RC_CYC);
          if (ref_left > 2'h1)
            ret_st <= SH_REF;
          else if (init_done_out)
            ret_st <= SH_IDLE;
          else
            ret_st <= SH_MRS;
          st <= SH_WAIT;
        end
        SH_MRS: begin
          mem_if.cs_n <= 1'b0;
          {mem_if.ras_n, mem_if.cas_n, mem_if.we_n} <= CMD_MRS;
          mem_if.addr <= '0;
          mem_if.addr[MR_BL_LSB+:3] <= BL_1;
          mem_if.addr[MR_CL_LSB+:3] <= CAS_LAT; // RULE9
          init_done_out <= 1'b1;
          wait_cnt <= 16'(MRD_CYC);
          ret_st   <= SH_IDLE;
          st       <= SH_WAIT;
        end
        SH_IDLE: begin
          if (ref_due) begin
            ref_left <= 2'h1;
            st       <= SH_REF;
          end else if (pdn_req_in) begin
            // every access auto-precharges, so all banks are idle here
            mem_if.clk_en    <= 1'b0; // RULE4
            powered_down_out <= 1'b1;
            st               <= SH_PDN;
          end else if (req_valid_in) begin
            req_ready_out <= 1'b1;
            acc_wr   <= req_write_in;
            acc_addr <= req_addr_in;
            acc_data <= req_wdata_in;
            acc_mask <= req_mask_in;
            mem_if.cs_n <= 1'b0;
            {mem_if.ras_n, mem_if.cas_n, mem_if.we_n} <= CMD_ACT; // RULE6
            {mem_if.bank_select_hi, mem_if.bank_select_lo}
              <= req_addr_in[UADDR_W-1-:BANK_W]; // RULE13 RULE14
            mem_if.addr <= req_addr_in[COL_W+:ROW_W]; // RULE15
            wait_cnt <= 16'(RCD_CYC);
            ret_st   <= SH_RW;
            st       <= SH_WAIT;
          end
        end
        SH_RW: begin
          mem_if.cs_n <= 1'b0;
          {mem_if.ras_n, mem_if.cas_n, mem_if.we_n}
            <= acc_wr ? CMD_WR : CMD_RD; // RULE17
          mem_if.addr <= '0;
          mem_if.addr[COL_W-1:0] <= acc_addr[COL_W-1:0];
          mem_if.addr[AP_BIT]    <= 1'b1; // RULE11
          mem_if.lower_byte_mask <= acc_mask[0];
          mem_if.upper_byte_mask <= acc_mask[1];
          mem_if.dq_ctl    <= acc_data;
          mem_if.dq_ctl_oe <= acc_wr;
          // row cycle plus latency covers data return and precharge
          wait_cnt <= 16'(RC_CYC) + 16'(CAS_LAT);
          ret_st   <= SH_IDLE;
          st       <= SH_WAIT;
        end
        SH_WAIT: begin
          if (wait_cnt <= 16'h0001)
            st <= ret_st;
          else
            wait_cnt <= wait_cnt - 16'h0001;
        end
        SH_PDN: begin
          if (!pdn_req_in || ref_due) begin
            mem_if.clk_en    <= 1'b1;
            powered_down_out <= 1'b0;
            wait_cnt <= 16'h0001;
            ret_st   <= SH_IDLE;
            st       <= SH_WAIT;
          end
        end
        default: st <= SH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read return at the programmed latency
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_cnt       <= 4'h0;
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      if (st == SH_RW && !acc_wr)
        rd_cnt <= 4'(CAS_LAT) + 4'h1; // RULE9
      else if (rd_cnt != 4'h0)
        rd_cnt <= rd_cnt - 4'h1;
      if (rd_cnt == 4'h1) begin
        rd_data_out  <= mem_if.data_lines;
        rd_valid_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/sdc_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_link_asserts (
  // clock and reset
  input wire logic                       ref_clk_in,
  input wire logic                       reset_in,
  // link pins
  input wire logic                       clk_en,
  input wire logic                       cs_n,
  input wire logic                       ras_n,
  input wire logic                       cas_n,
  input wire logic                       we_n,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr,
  input wire logic                       lower_byte_mask,
  input wire logic                       upper_byte_mask,
  input wire logic                       dq_ctl_oe,
  input wire logic [sdc_pkg::DQ_W-1:0]   dq_dev,
  input wire logic                       dq_dev_oe
);
  import sdc_pkg::*;
  logic [2:0] cmd;
  logic       rd_cmd;
  assign cmd    = {ras_n, cas_n, we_n};
  assign rd_cmd = !cs_n && cmd == CMD_RD;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_act;
    !cs_n && clk_en && cmd == CMD_ACT;
  endsequence
  sequence s_rw;
    !cs_n && clk_en && (cmd == CMD_RD || cmd == CMD_WR);
  endsequence
  // the host is built for latency two; masked words are never driven
  sequence s_rd_live;
    rd_cmd && clk_en && !(lower_byte_mask && upper_byte_mask);
  endsequence
  dual_drive_a: assert property (!(dq_dev_oe && dq_ctl_oe))
    else $error("both ends drive the data lines");
  read_latency_a: assert property (s_rd_live |-> ##2 dq_dev_oe)
    else $error("read data missing at latency two");
  drive_cause_a: assert property (
    $rose(dq_dev_oe) |-> $past(rd_cmd, 2))
    else $error("device drove data without a read");
  single_word_a: assert property ($rose(dq_dev_oe) |=> !dq_dev_oe)
    else $error("burst longer than one word");
  open_first_a: assert property (s_act |-> ##[1:4] s_rw)
    else $error("row opened but no access followed");
  auto_close_a: assert property (s_rw |-> addr[AP_BIT])
    else $error("access without auto precharge");
  write_drive_a: assert property (s_rw and !we_n |-> dq_ctl_oe)
    else $error("write without data drive");
  freeze_hold_a: assert property (
    !clk_en |-> ##2 $stable({dq_dev_oe, dq_dev}))
    else $error("outputs moved while clock disabled");
  mode_word_a: assert property (
    !cs_n && cmd == CMD_MRS |-> addr[6:0] == {CL_RST, 1'b0, BL_1})
    else $error("mode word not single word latency two");
endmodule
`default_nettype wire

// File: test/sdram_clock_bank_burst_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_clock_bank_burst_control_tb;
  import sdc_pkg::*;
  logic                 ref_clk_in = 1'b0;
  logic                 reset_in   = 1'b1;
  logic                 req_valid  = 1'b0;
  logic                 req_write  = 1'b0;
  logic [UADDR_W-1:0]   req_addr   = '0;
  logic [DQ_W-1:0]      req_wdata  = '0;
  logic [1:0]           req_mask   = '0;
  logic                 pdn_req    = 1'b0;
  logic                 ready, rd_valid, init_done, host_pdn, dev_pdn, dev_sr;
  logic [DQ_W-1:0]      rd_data;
  logic [3:0]           bank_open;
  int                   n_fail = 0;
  int                   total_checks = 0;
  int                   seed = 43;
  logic [DQ_W-1:0]      mem [logic [UADDR_W-1:0]];
  logic [UADDR_W-1:0]   pool [8];
  always #20 ref_clk_in = ~ref_clk_in;
  sdc_mem_if mem_if ();
  // a 16-row array keeps the model small; addresses stay inside it
  sdc_device #(.ROWS_W(4), .COLS_W(COL_W)) i_sdc_device (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .mem_if(mem_if),
    .powered_down_out(dev_pdn), .self_refresh_out(dev_sr),
    .bank_open_out(bank_open));
  sdc_host #(.INIT_WAIT(20), .REFI(200), .CAS_LAT(CL_RST)) i_sdc_host (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .mem_if(mem_if),
    .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_mask_in(req_mask),
    .pdn_req_in(pdn_req), .req_ready_out(ready), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .init_done_out(init_done),
    .powered_down_out(host_pdn));
  sdc_link_asserts i_sdc_link_asserts (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en(mem_if.clk_en),
    .cs_n(mem_if.cs_n), .ras_n(mem_if.ras_n), .cas_n(mem_if.cas_n),
    .we_n(mem_if.we_n), .addr(mem_if.addr),
    .lower_byte_mask(mem_if.lower_byte_mask),
    .upper_byte_mask(mem_if.upper_byte_mask), .dq_ctl_oe(mem_if.dq_ctl_oe),
    .dq_dev(mem_if.dq_dev), .dq_dev_oe(mem_if.dq_dev_oe));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] o, n,
                                        input logic [1:0] m);
    return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // valid is held until the host takes it, then dropped
  task automatic access(input logic w, input logic [UADDR_W-1:0] a,
                        input logic [15:0] d, input logic [1:0] m);
    int n;
    @(posedge ref_clk_in);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    req_mask  <= w ? m : 2'h0;
    for (n = 0; n < 3000 && ready !== 1'b1; n++) @(negedge ref_clk_in);
    check("ready", 16'h1, {15'h0, ready});
    @(posedge ref_clk_in);
    req_valid <= 1'b0;
    if (w) begin
      mem[a] = merge(mem[a], d, m);
    end else begin
      for (n = 0; n < 100 && rd_valid !== 1'b1; n++) @(negedge ref_clk_in);
      check("read data", mem[a], rd_data);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    int i, n, k;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (n = 0; n < 300 && init_done !== 1'b1; n++) @(negedge ref_clk_in);
    check("init done", 16'h1, {15'h0, init_done});
    for (i = 0; i < 8; i++) begin
      pool[i] = {i[1:0], 8'h00, 4'($random(seed)), 8'($random(seed))};
      access(1'b1, pool[i], 16'($random(seed)), 2'h0);
    end
    for (i = 0; i < 8; i++) access(1'b0, pool[i], 16'h0, 2'h0);
    $display("test banks done");
    access(1'b1, pool[1], 16'hFFFF, 2'h3);
    access(1'b0, pool[1], 16'h0, 2'h0);
    for (i = 0; i < 40; i++) begin
      k = {$random(seed)} % 8;
      access(1'($random(seed)), pool[k], 16'($random(seed)),
             2'($random(seed)));
    end
    $display("test random done");
    @(posedge ref_clk_in);
    pdn_req <= 1'b1;
    for (n = 0; n < 3000 && dev_pdn !== 1'b1; n++) @(negedge ref_clk_in);
    check("power down", 16'h1, {15'h0, dev_pdn});
    check("banks, self refresh", 16'h0, {11'h0, dev_sr, bank_open});
    @(posedge ref_clk_in);
    pdn_req <= 1'b0;
    for (n = 0; n < 300 && dev_pdn !== 1'b0; n++) @(negedge ref_clk_in);
    check("power down exit", 16'h0, {14'h0, host_pdn, dev_pdn});
    for (i = 0; i < 8; i++) access(1'b0, pool[i], 16'h0, 2'h0);
    $display("test power down done");
    conclude();
  end
  initial begin
    #(40 * 60000);
    n_fail++;
    $display("unexpected timeout: expected finish, seen hang");
    conclude();
  end
endmodule
`default_nettype wire
